// ==== rtl/srr_ctrl.sv ====
/*
 Safe referencing and retract controller for one drive axis.
 Assumes position, motion and limit inputs come from logic on ref_clk;
 only the retract pin is asynchronous and is synchronised here.
*/
// The address-and-strobe port and the register addresses were left to the implementer.
// Behaviour
// - Retract rise arms only safely referenced, violated axes
// - Retract turns limit monitor off, picks direction
// - Retract fall drops direction, restores limit monitor
// - External reference valid after accept code 89
// - Positioner reference taken directly, even moving
// - Agreement timeout raises message value 1002
// - Valid agreement sets safely referenced
// - Separate referenced diagnostic bit
// - Reference evaluated only when function enabled
// - Safe position clamped to 737280000 range
// - Internal diagnostic mirrors safe position
// - Restart uses stored agreement, subsequent referencing
// - Subsequent referencing runs plausibility check
// - Within tolerance of stored position becomes safe
// - Subsequent fault falls back to initial referencing
// - Positioner with absolute encoder self-references
// - Lower violation positive, upper violation negative
// - Reported limit active ANDs safely referenced
`default_nettype none

module srr_ctrl
	import srr_pkg::*;
#(
	parameter int unsigned AGREE_CYC = AGREE_CYC_DEF,
	parameter int          INT_FRAC  = 4
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic [7:0]            regAddr,
	input  wire logic [31:0]           regWdata,
	input  wire logic                  regWr,
	input  wire logic                  regRd,
	output logic      [31:0]           regRdata,
	input  wire logic                  retractPin,
	input  wire logic [31:0]           actPos,
	input  wire logic                  axisMoving,
	input  wire logic                  lowerViolated,
	input  wire logic                  upperViolated,
	input  wire logic                  posnRefValid,
	input  wire logic [31:0]           posnRefPos,
	input  wire logic                  restartReq,
	input  wire logic                  subseqFault,
	output logic                       safelyReferenced,
	output logic                       referenced,
	output logic                       limitMonOn,
	output logic                       dirPosSel,
	output logic                       dirNegSel,
	output logic                       limitActive,
	output logic                       motionMsg,
	output logic      [15:0]           motionMsgValue,
	output logic      [31:0]           safePosDiag,
	output logic      [31+INT_FRAC:0]  intPosDiag
);

	typedef struct packed {
		srr_state_t        st;
		logic [CTRL_W-1:0] ctrl;
		logic [31:0]       refPos;
		logic [31:0]       tol;
		logic [31:0]       stored;
		logic [31:0]       offset;
		logic [7:0]        agA;
		logic [7:0]        agB;
		logic              agreeMem;
		logic              referenced;
		logic              safeRef;
		logic              retract;
		logic              dirPos;
		logic              dirNeg;
		logic              retPrev;
		logic              msg;
		logic [15:0]       faultVal;
		logic [31:0]       timer;
		logic [31:0]       safePos;
		logic [31:0]       rdata;
	} srr_regs_t;

	localparam srr_regs_t REGS_RST = '{st: S_UNREF, ctrl: CTRL_RST, default: '0};
	localparam logic [31:0] TIMER_LAST = 32'(AGREE_CYC - 1);

	srr_regs_t q;
	srr_regs_t d;

	logic               retractSync;
	logic               acceptWr;
	logic               extRef;
	logic               posRef;
	logic               autoRef;
	logic               refEvt;
	logic [31:0]        newRef;
	logic signed [32:0] devS;
	logic [32:0]        absDev;
	logic               plausOk;
	logic               agreeOk;
	logic               timerDone;
	logic               retRise;
	logic               retFall;
	logic signed [32:0] posRaw;
	logic [31:0]        statusWord;

	srr_sync #(.WIDTH(1)) u_retract_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.asyncIn (retractPin),
		.syncOut (retractSync)
	);

	// Accept code only counts at standstill; a moving write is ignored
	assign acceptWr = regWr && (regAddr == ADDR_ACCEPT) && (regWdata[7:0] == ACCEPT_CODE);
	assign extRef   = acceptWr && !axisMoving;
	assign posRef   = posnRefValid && q.ctrl[CTRL_POSITIONER];
	assign autoRef  = (q.st == S_SUBSEQ) && q.ctrl[CTRL_POSITIONER]
		&& q.ctrl[CTRL_ABS_ENC] && !q.referenced;
	assign refEvt   = q.ctrl[CTRL_LIM_EN] && (extRef || posRef || autoRef);
	assign newRef   = posRef ? posnRefPos : (extRef ? q.refPos : actPos);

	// Widened by one bit so the deviation can never wrap
	assign devS      = $signed({newRef[31], newRef}) - $signed({q.stored[31], q.stored});
	assign absDev    = devS[32] ? 33'(-devS) : 33'(devS);
	assign plausOk   = absDev <= {1'b0, q.tol};
	assign agreeOk   = (q.agA == AGREE_CODE) && (q.agB == AGREE_CODE);
	assign timerDone = q.timer >= TIMER_LAST;
	assign retRise   = retractSync && !q.retPrev;
	assign retFall   = !retractSync && q.retPrev;
	// Widened so a sum near full scale clamps instead of wrapping
	assign posRaw    = $signed({actPos[31], actPos}) + $signed({q.offset[31], q.offset});

	always_comb begin
		statusWord = '0;
		statusWord[STAT_SAFE_REF]   = q.safeRef;
		statusWord[STAT_REFERENCED] = q.referenced;
		statusWord[STAT_LIM_ACT]    = limitActive;
		statusWord[STAT_LIM_ON]     = limitMonOn;
		statusWord[STAT_DIR_POS]    = q.dirPos;
		statusWord[STAT_DIR_NEG]    = q.dirNeg;
		statusWord[STAT_RETRACT]    = q.retract;
		statusWord[STAT_AGREE_MEM]  = q.agreeMem;
		statusWord[STAT_ROTARY]     = q.ctrl[CTRL_ROTARY];
		statusWord[STAT_STATE_LSB +: 4] = q.st;
	end

	always_comb begin
		d       = q;
		d.msg   = 1'b0;
		d.rdata = '0;
		d.retPrev = retractSync;

		if (regWr) begin
			case (regAddr)
				ADDR_CTRL:    d.ctrl   = regWdata[CTRL_W-1:0];
				ADDR_REFPOS:  d.refPos = regWdata;
				ADDR_AGREE_A: d.agA    = regWdata[7:0];
				ADDR_AGREE_B: d.agB    = regWdata[7:0];
				ADDR_TOL:     d.tol    = regWdata;
				ADDR_STORED:  d.stored = regWdata;
				default:      d.ctrl   = d.ctrl;
			endcase
		end

		if (regRd) begin
			case (regAddr)
				ADDR_CTRL:    d.rdata = {{(32-CTRL_W){1'b0}}, q.ctrl};
				ADDR_REFPOS:  d.rdata = q.refPos;
				ADDR_AGREE_A: d.rdata = {24'h00_0000, q.agA};
				ADDR_AGREE_B: d.rdata = {24'h00_0000, q.agB};
				ADDR_TOL:     d.rdata = q.tol;
				ADDR_STORED:  d.rdata = q.stored;
				ADDR_STATUS:  d.rdata = statusWord;
				ADDR_SAFEPOS: d.rdata = q.safePos;
				ADDR_INTPOS:  d.rdata = q.safePos;
				ADDR_FAULT:   d.rdata = {16'h0000, q.faultVal};
				default:      d.rdata = '0;
			endcase
		end

		// Clamp keeps the diagnostic inside the reportable span
		if (posRaw > $signed({1'b0, POS_LIMIT})) begin
			d.safePos = POS_LIMIT;
		end else if (posRaw < -$signed({1'b0, POS_LIMIT})) begin
			d.safePos = 32'(-$signed(POS_LIMIT));
		end else begin
			d.safePos = posRaw[31:0];
		end

		case (q.st)
			S_UNREF: begin
				if (refEvt) begin
					d.referenced = 1'b1;
					d.offset = newRef - actPos;
					d.st     = S_AGREE;
					d.timer  = '0;
					d.agA    = '0;
					d.agB    = '0;
				end
			end
			S_SUBSEQ: begin
				if (subseqFault) begin
					d.st       = S_UNREF;
					d.agreeMem = 1'b0;
				end else if (refEvt) begin
					d.referenced = 1'b1;
					d.offset = newRef - actPos;
					if (plausOk) begin
						d.st      = S_SAFE;
						d.safeRef = 1'b1;
					end else begin
						d.st       = S_AGREE;
						d.agreeMem = 1'b0;
						d.timer    = '0;
						d.agA      = '0;
						d.agB      = '0;
					end
				end
			end
			S_AGREE: begin
				if (refEvt) begin
					d.offset = newRef - actPos;
					d.timer  = '0;
				end else if (agreeOk) begin
					d.st       = S_SAFE;
					d.safeRef  = 1'b1;
					d.agreeMem = 1'b1;
				end else if (timerDone) begin
					d.st       = S_UNREF;
					d.msg      = 1'b1;
					d.faultVal = FAULT_AGREE_TO;
				end else begin
					d.timer = q.timer + 32'h0000_0001;
				end
			end
			S_SAFE: begin
				// A fresh reference needs a fresh agreement
				if (refEvt) begin
					d.offset  = newRef - actPos;
					d.st      = S_AGREE;
					d.safeRef = 1'b0;
					d.timer   = '0;
					d.agA     = '0;
					d.agB     = '0;
				end
			end
			default: d.st = S_UNREF;
		endcase

		if (retRise && q.safeRef && (lowerViolated || upperViolated)) begin
			d.retract = 1'b1;
			d.dirPos  = lowerViolated;
			d.dirNeg  = upperViolated && !lowerViolated;
		end
		if (retFall) begin
			d.retract = 1'b0;
			d.dirPos  = 1'b0;
			d.dirNeg  = 1'b0;
		end

		if (restartReq) begin
			d.st         = q.agreeMem ? S_SUBSEQ : S_UNREF;
			d.referenced = 1'b0;
			d.safeRef    = 1'b0;
			d.retract    = 1'b0;
			d.dirPos     = 1'b0;
			d.dirNeg     = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			q <= REGS_RST;
		end else begin
			q <= d;
		end
	end

	assign regRdata         = q.rdata;
	assign safelyReferenced = q.safeRef;
	assign referenced       = q.referenced;
	assign limitMonOn       = q.ctrl[CTRL_LIM_EN] && !q.retract;
	assign dirPosSel        = q.dirPos;
	assign dirNegSel        = q.dirNeg;
	assign limitActive      = limitMonOn && q.safeRef;
	assign motionMsg        = q.msg;
	assign motionMsgValue   = q.faultVal;
	assign safePosDiag      = q.safePos;
	// Same value, finer internal unit
	assign intPosDiag       = {q.safePos, {INT_FRAC{1'b0}}};

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	chk_retract_gate: assert property ($rose(q.retract) |->
		$past(q.safeRef) && ($past(lowerViolated) || $past(upperViolated)))
		else $error("retract armed without reference or violation");

	chk_retract_mon: assert property (q.retract |->
		!limitMonOn && (q.dirPos != q.dirNeg))
		else $error("retract without single direction monitor");

	chk_retract_end: assert property (retFall |=>
		!q.retract && !dirPosSel && !dirNegSel && (limitMonOn == q.ctrl[CTRL_LIM_EN]))
		else $error("retract fall did not restore limit monitor");

	chk_ref_cause: assert property ($rose(q.referenced) |->
		$past(posnRefValid) || $past(autoRef) || $past(acceptWr && !axisMoving))
		else $error("referenced without accept code or positioner");

	chk_agree_to: assert property ((q.st == S_AGREE) && timerDone && !agreeOk
		&& !refEvt && !restartReq |=> motionMsg && (motionMsgValue == FAULT_AGREE_TO))
		else $error("agreement timeout message missing");

	chk_agree_ok: assert property ((q.st == S_AGREE) && agreeOk && !refEvt
		&& !restartReq |=> safelyReferenced ##1 q.agreeMem)
		else $error("valid agreement did not set safely referenced");

	chk_timer_bnd: assert property ((q.st == S_AGREE) |-> q.timer <= TIMER_LAST)
		else $error("agreement window overran");

	chk_no_eval: assert property (!q.ctrl[CTRL_LIM_EN] |=> !$rose(q.referenced))
		else $error("reference taken while function disabled");

	chk_pos_range: assert property ($signed(safePosDiag) <= $signed(POS_LIMIT)
		&& $signed(safePosDiag) >= -$signed(POS_LIMIT))
		else $error("safe position out of range");

	chk_plaus_bad: assert property ((q.st == S_SUBSEQ) && refEvt && !plausOk && !subseqFault
		&& !restartReq |=> !safelyReferenced && (q.st == S_AGREE))
		else $error("implausible position not sent back to agreement");

	chk_lim_and: assert property (!safelyReferenced |-> !limitActive)
		else $error("limit active reported while unreferenced");

	cov_retract: cover property ($rose(q.retract) ##[1:1000] $fell(q.retract));
	cov_agree: cover property ((q.st == S_AGREE) ##1 (q.st == S_SAFE));
	cov_timeout: cover property (motionMsg);
	cov_subseq: cover property ((q.st == S_SUBSEQ) ##1 (q.st == S_SAFE));

endmodule : srr_ctrl

`default_nettype wire

// ==== rtl/srr_pkg.sv ====
/*
 Shared constants for the safe referencing and retract controller:
 register offsets, field positions, codes, timing and state encoding.
 Assumes a 25 MHz system clock and a byte-addressed plain register port.
*/
`default_nettype none

package srr_pkg;

	localparam int unsigned CLK_HZ        = 25_000_000;
	localparam int unsigned AGREE_WIN_MS  = 2000;
	localparam int unsigned AGREE_CYC_DEF = AGREE_WIN_MS * (CLK_HZ / 1000);

	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_REFPOS  = 8'h04;
	localparam logic [7:0] ADDR_ACCEPT  = 8'h08;
	localparam logic [7:0] ADDR_AGREE_A = 8'h0C;
	localparam logic [7:0] ADDR_AGREE_B = 8'h10;
	localparam logic [7:0] ADDR_TOL     = 8'h14;
	localparam logic [7:0] ADDR_STORED  = 8'h18;
	localparam logic [7:0] ADDR_STATUS  = 8'h1C;
	localparam logic [7:0] ADDR_SAFEPOS = 8'h20;
	localparam logic [7:0] ADDR_INTPOS  = 8'h24;
	localparam logic [7:0] ADDR_FAULT   = 8'h28;

	localparam int CTRL_W          = 4;
	localparam int CTRL_LIM_EN     = 0;
	localparam int CTRL_ROTARY     = 1;
	localparam int CTRL_ABS_ENC    = 2;
	localparam int CTRL_POSITIONER = 3;
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

	localparam int STAT_SAFE_REF  = 0;
	localparam int STAT_REFERENCED = 1;
	localparam int STAT_LIM_ACT   = 2;
	localparam int STAT_LIM_ON    = 3;
	localparam int STAT_DIR_POS   = 4;
	localparam int STAT_DIR_NEG   = 5;
	localparam int STAT_RETRACT   = 6;
	localparam int STAT_AGREE_MEM = 7;
	localparam int STAT_ROTARY    = 8;
	localparam int STAT_STATE_LSB = 12;

	localparam logic [7:0]  ACCEPT_CODE    = 8'h59;
	localparam logic [7:0]  AGREE_CODE     = 8'hAC;
	localparam logic [15:0] FAULT_AGREE_TO = 16'h03EA;
	localparam logic [31:0] POS_LIMIT      = 32'h2BF2_0000;

	typedef enum logic [3:0] {
		S_UNREF  = 4'h1,
		S_AGREE  = 4'h2,
		S_SUBSEQ = 4'h4,
		S_SAFE   = 4'h8
	} srr_state_t;

endpackage : srr_pkg

`default_nettype wire

// ==== rtl/srr_sync.sv ====
/*
 Two-flop synchroniser for asynchronous level inputs.
 Assumes the input is a slow level, held far longer than one clock.
*/
`default_nettype none

module srr_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta_q  <= '0;
			syncOut <= '0;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule : srr_sync

`default_nettype wire

// ==== tb/srr_partner.sv ====
/*
 Far-side model: fail-safe retract input and the two limit sensors.
 Assumes bench commands on ref_clk; the pin moves off the clock grid.
*/
`default_nettype none

module srr_partner (
	input  wire logic cmdRetract,
	input  wire logic cmdLower,
	input  wire logic cmdUpper,
	output wire logic retractPin,
	output var  logic lowerViolated,
	output var  logic upperViolated
);
	timeunit 1ns;
	timeprecision 1ns;

	// Pin lags its command by a non-cycle delay, so the sync stage is exercised
	assign #13 retractPin = cmdRetract;
	always_comb lowerViolated = cmdLower;
	always_comb upperViolated = cmdUpper;
endmodule : srr_partner

`default_nettype wire

// ==== tb/srr_ctrl_tb.sv ====
/*
 Self-checking bench for srr_ctrl: register tasks and sequenced tests.
 Assumes a shortened agreement window of 20 cycles.
*/
`default_nettype none

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("ERROR %0t mismatch", $time); end end

module srr_ctrl_tb;
	import srr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic        ref_clk, rst_n, regWr, regRd, axisMoving, posnRefValid, restartReq, subseqFault;
	logic        cmdRetract, cmdLower, cmdUpper, retractPin, lowerViolated, upperViolated;
	logic        safelyReferenced, referenced, limitMonOn, dirPosSel, dirNegSel, limitActive, motionMsg;
	logic [7:0]  regAddr;
	logic [15:0] motionMsgValue;
	logic [31:0] regWdata, regRdata, actPos, posnRefPos, safePosDiag, d;
	logic [35:0] intPosDiag;
	int          errors, compares, cycles, i;

	srr_ctrl #(.AGREE_CYC(20), .INT_FRAC(4)) i_srr_ctrl (
		.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .retractPin(retractPin),
		.actPos(actPos), .axisMoving(axisMoving), .lowerViolated(lowerViolated),
		.upperViolated(upperViolated), .posnRefValid(posnRefValid), .posnRefPos(posnRefPos),
		.restartReq(restartReq), .subseqFault(subseqFault), .safelyReferenced(safelyReferenced),
		.referenced(referenced), .limitMonOn(limitMonOn), .dirPosSel(dirPosSel),
		.dirNegSel(dirNegSel), .limitActive(limitActive), .motionMsg(motionMsg),
		.motionMsgValue(motionMsgValue), .safePosDiag(safePosDiag), .intPosDiag(intPosDiag)
	);

	srr_partner i_srr_partner (
		.cmdRetract(cmdRetract), .cmdLower(cmdLower), .cmdUpper(cmdUpper),
		.retractPin(retractPin), .lowerViolated(lowerViolated), .upperViolated(upperViolated)
	);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic wrap_up();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	// Ceiling far above the few hundred cycles the tests need
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 4000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		regWr    <= 1'b1;
		regAddr  <= a;
		regWdata <= v;
		@(posedge ref_clk);
		regWr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask : rd

	task automatic ext_ref(input logic [31:0] p, input logic mv);
		@(posedge ref_clk);
		axisMoving <= mv;
		wr(ADDR_REFPOS, p);
		wr(ADDR_ACCEPT, {24'h0, ACCEPT_CODE});
		cyc(2);
	endtask : ext_ref

	// Operator confirms by hand; nothing sets this automatically
	task automatic agree();
		wr(ADDR_AGREE_A, {24'h0, AGREE_CODE});
		wr(ADDR_AGREE_B, {24'h0, AGREE_CODE});
		cyc(2);
	endtask : agree

	task automatic restart();
		@(posedge ref_clk);
		restartReq <= 1'b1;
		@(posedge ref_clk);
		restartReq <= 1'b0;
		cyc(2);
	endtask : restart

	task automatic set_pos(input logic [31:0] p);
		@(posedge ref_clk);
		actPos <= p;
		cyc(3);
	endtask : set_pos

	task automatic retr(input logic lo, input logic up, input logic ep, input logic en, input logic sr);
		@(posedge ref_clk);
		cmdLower   <= lo;
		cmdUpper   <= up;
		cmdRetract <= 1'b1;
		cyc(6);
		`CHK(dirPosSel, ep);
		`CHK(dirNegSel, en);
		`CHK(limitMonOn, ~(ep | en));
		`CHK(safelyReferenced, sr);
		`CHK(limitActive, sr & ~(ep | en));
		@(posedge ref_clk);
		cmdRetract <= 1'b0;
		cyc(6);
		`CHK({dirPosSel, dirNegSel, limitMonOn}, 3'b001);
	endtask : retr

	initial begin
		rst_n = 1'b0; regAddr = 8'h00; regWdata = 32'h0; regWr = 1'b0; regRd = 1'b0;
		actPos = 32'h0; axisMoving = 1'b0; posnRefValid = 1'b0; posnRefPos = 32'h0;
		restartReq = 1'b0; subseqFault = 1'b0; cmdRetract = 1'b0; cmdLower = 1'b0; cmdUpper = 1'b0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		cyc(1);
		rd(ADDR_STATUS, d);
		`CHK(d, 32'h0000_1000);
		rd(8'hFC, d);
		`CHK(d, 32'h0);
		ext_ref(32'h64, 1'b0);
		`CHK(referenced, 1'b0);
		wr(ADDR_CTRL, 32'h1);
		ext_ref(32'h64, 1'b1);
		`CHK(referenced, 1'b0);
		ext_ref(32'h64, 1'b0);
		`CHK({referenced, safelyReferenced}, 2'b10);
		for (i = 0; i < 40 && motionMsg !== 1'b1; i++) cyc(1);
		`CHK(motionMsg, 1'b1);
		`CHK(i > 10 && i < 25, 1'b1);
		`CHK(motionMsgValue, FAULT_AGREE_TO);
		rd(ADDR_FAULT, d);
		`CHK(d, {16'h0000, FAULT_AGREE_TO});
		`CHK(safelyReferenced, 1'b0);
		retr(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		ext_ref(32'h64, 1'b0);
		agree();
		`CHK({safelyReferenced, limitActive}, 2'b11);
		`CHK(safePosDiag, 32'h64);
		`CHK(intPosDiag, 36'h640);
		rd(ADDR_SAFEPOS, d);
		`CHK(d, 32'h64);
		retr(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
		retr(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
		retr(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
		retr(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		set_pos(32'h7000_0000);
		`CHK(safePosDiag, POS_LIMIT);
		set_pos(32'h9000_0000);
		`CHK(safePosDiag, -POS_LIMIT);
		set_pos(32'h0);
		wr(ADDR_STORED, 32'h64);
		wr(ADDR_TOL, 32'hA);
		restart();
		rd(ADDR_STATUS, d);
		`CHK(d[15:12], 4'h4);
		ext_ref(32'h6E, 1'b0);
		rd(ADDR_STATUS, d);
		`CHK({d[15:12], safelyReferenced}, 5'h11);
		restart();
		ext_ref(32'h6F, 1'b0);
		rd(ADDR_STATUS, d);
		`CHK({d[15:12], safelyReferenced}, 5'h04);
		agree();
		restart();
		@(posedge ref_clk);
		subseqFault <= 1'b1;
		@(posedge ref_clk);
		subseqFault <= 1'b0;
		restart();
		rd(ADDR_STATUS, d);
		`CHK(d[15:12], 4'h1);
		wr(ADDR_CTRL, 32'h9);
		@(posedge ref_clk);
		axisMoving   <= 1'b1;
		posnRefValid <= 1'b1;
		posnRefPos   <= 32'h12C;
		@(posedge ref_clk);
		posnRefValid <= 1'b0;
		cyc(2);
		rd(ADDR_STATUS, d);
		`CHK({d[15:12], referenced}, 5'h05);
		agree();
		wr(ADDR_CTRL, 32'hD);
		restart();
		cyc(2);
		`CHK(referenced, 1'b1);
		wrap_up();
	end
endmodule : srr_ctrl_tb

`default_nettype wire
